// [apc_regs.svh]
// Register offsets, field positions, reset values and codes for the PWM and serial port block
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

// Register offsets
`define APC_MODCFG_OFS 8'h02
`define APC_SAPFMT_OFS 8'h03

// Reset values
`define APC_MODCFG_RST 8'h62
`define APC_SAPFMT_RST 8'h04

// Modulator config field positions
`define APC_MOD_PWM_LSB 4
`define APC_MOD_OSR_BIT 2
`define APC_MOD_PHASE_LSB 0

// Serial port field positions
`define APC_SAP_RATE_LSB 6
`define APC_SAP_HALF_BIT 5
`define APC_SAP_SLOT16_BIT 4
`define APC_SAP_SWAP_BIT 3
`define APC_SAP_FMT_LSB 0

// Switching-rate codes
`define APC_PWM_8X 3'h0
`define APC_PWM_10X 3'h1
`define APC_PWM_38X 3'h5
`define APC_PWM_44X 3'h6
`define APC_PWM_48X 3'h7

// Sample-rate codes
`define APC_RATE_44K1 2'h0
`define APC_RATE_48K 2'h1
`define APC_RATE_96K 2'h2
`define APC_RATE_RSVD 2'h3

// Format codes
`define APC_FMT_RJ24 3'h0
`define APC_FMT_RJ20 3'h1
`define APC_FMT_RJ18 3'h2
`define APC_FMT_RJ16 3'h3
`define APC_FMT_I2S 3'h4
`define APC_FMT_LJ 3'h5
`define APC_FMT_DSP 3'h6
`define APC_FMT_RSVD 3'h7

// Slot layout
`define APC_HALF_SLOTS 3'h4

`endif

// [apc_pkg.sv]
// Types shared by the PWM and serial port configuration block
`default_nettype none
package apc_pkg;

  // Modulator config register layout
  typedef struct packed {
    logic rsvd7;
    logic [2:0] pwm_rate;
    logic rsvd3;
    logic osr_sel;
    logic [1:0] phase;
  } apc_modcfg_t;

  // Serial port format register layout
  typedef struct packed {
    logic [1:0] rate;
    logic slot_half;
    logic slot16;
    logic swap;
    logic [2:0] fmt;
  } apc_sapcfg_t;

  // Framing families of the input format
  typedef enum logic [1:0] {
    APC_FRAME_RJ,
    APC_FRAME_I2S,
    APC_FRAME_LJ,
    APC_FRAME_DSP
  } apc_frame_t;

  // Decoded settings for the datapath
  typedef struct packed {
    logic [5:0] pwm_mult;
    logic [7:0] osr;
    logic [5:0] phase_deg;
    logic [9:0] fs_khz_x10;
    logic [5:0] slot_bits;
    logic slot_wide;
    apc_frame_t frame;
    logic [4:0] rj_bits;
    logic [3:0][2:0] slot_map;
    logic pwm_unsupported;
  } apc_decoded_t;

endpackage : apc_pkg
`default_nettype wire

// [apc_decode.sv]
// Decoder from stored register fields to datapath settings
`timescale 1ns/100ps
`default_nettype none
`include "apc_regs.svh"

module apc_decode (
  // Stored fields
  input wire apc_pkg::apc_modcfg_t mod_cfg,
  input wire apc_pkg::apc_sapcfg_t sap_cfg,
  // Decoded settings
  output apc_pkg::apc_decoded_t dec
);
  import apc_pkg::*;

  // Slot index per channel, one driver per element
  wire logic [3:0][2:0] slot_map;

  // Modulator and serial port settings
  always_comb begin
    dec = '0;
    dec.slot_map = slot_map;
    case (mod_cfg.pwm_rate)
      `APC_PWM_8X: dec.pwm_mult = 6'h08;
      `APC_PWM_10X: dec.pwm_mult = 6'h0a;
      `APC_PWM_38X: dec.pwm_mult = 6'h26;
      `APC_PWM_44X: dec.pwm_mult = 6'h2c;
      `APC_PWM_48X: dec.pwm_mult = 6'h30;
      default: dec.pwm_mult = 6'h2c;
    endcase
    dec.pwm_unsupported = (mod_cfg.pwm_rate == `APC_PWM_48X) &&
                          (sap_cfg.rate != `APC_RATE_44K1);
    dec.osr = mod_cfg.osr_sel ? 8'h80 : 8'h40;
    case (mod_cfg.phase)
      2'h0: dec.phase_deg = 6'h00;
      2'h1: dec.phase_deg = 6'h1e;
      2'h2: dec.phase_deg = 6'h2d;
      default: dec.phase_deg = 6'h3c;
    endcase
    case (sap_cfg.rate)
      `APC_RATE_44K1: dec.fs_khz_x10 = 10'h1b9;
      `APC_RATE_48K: dec.fs_khz_x10 = 10'h1e0;
      `APC_RATE_96K: dec.fs_khz_x10 = 10'h3c0;
      default: dec.fs_khz_x10 = 10'h1b9;
    endcase
    dec.slot_wide = ~sap_cfg.slot16;
    dec.slot_bits = sap_cfg.slot16 ? 6'h10 : 6'h20;
    case (sap_cfg.fmt)
      `APC_FMT_RJ24: begin
        dec.frame = APC_FRAME_RJ;
        dec.rj_bits = 5'h18;
      end
      `APC_FMT_RJ20: begin
        dec.frame = APC_FRAME_RJ;
        dec.rj_bits = 5'h14;
      end
      `APC_FMT_RJ18: begin
        dec.frame = APC_FRAME_RJ;
        dec.rj_bits = 5'h12;
      end
      `APC_FMT_RJ16: begin
        dec.frame = APC_FRAME_RJ;
        dec.rj_bits = 5'h10;
      end
      `APC_FMT_LJ: dec.frame = APC_FRAME_LJ;
      `APC_FMT_DSP: dec.frame = APC_FRAME_DSP;
      default: dec.frame = APC_FRAME_I2S;
    endcase
  end

  // Per-channel slot routing
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_slot
      logic [1:0] src;
      assign src = sap_cfg.swap ? (2'(ch) ^ 2'h2) : 2'(ch);
      assign slot_map[ch] = (sap_cfg.slot_half ? `APC_HALF_SLOTS : 3'h0) + {1'b0, src};
    end
  endgenerate

endmodule : apc_decode
`default_nettype wire

// [apc_audio_port_pwm_config.sv]
// Configuration registers for modulator and serial audio port
//
// Overview of operation
// - PWM rate code selects fs multiple
// - Oversample bit picks 64x or 128x
// - Phase field sets channel switching offset
// - Rate field selects 44.1, 48, 96 kHz
// - Slot half bit picks first/last slots
// - Slot width bit selects 16 or wide
// - Swap bit exchanges channels 1/3 and 2/4
// - Format codes 0-3 select right-justified widths
// - Format codes 4-6 select I2S, LJ, DSP
// - Serial port word resets to 0x04
`timescale 1ns/100ps
`default_nettype none
`include "apc_regs.svh"

module apc_audio_port_pwm_config (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Decoded settings
  output apc_pkg::apc_decoded_t cfg_out,
  output logic [2:0] serial_audio_port_fmt
);
  import apc_pkg::*;

  apc_modcfg_t modulator_config_reg;
  apc_modcfg_t modulator_config_next;
  apc_sapcfg_t serial_port_format_reg;
  apc_sapcfg_t serial_port_format_next;
  apc_modcfg_t mod_wr;
  apc_sapcfg_t sap_wr;
  apc_decoded_t dec;
  logic mod_sel;
  logic sap_sel;

  // Address decode
  assign mod_sel = (reg_addr == `APC_MODCFG_OFS);
  assign sap_sel = (reg_addr == `APC_SAPFMT_OFS);
  assign mod_wr = apc_modcfg_t'(reg_wdata);
  assign sap_wr = apc_sapcfg_t'(reg_wdata);

  // Next value of modulator config
  always_comb begin
    modulator_config_next = modulator_config_reg;
    if (reg_wr && mod_sel) begin
      modulator_config_next = mod_wr;
      if (mod_wr.pwm_rate inside {3'h2, 3'h3, 3'h4}) begin
        modulator_config_next.pwm_rate = modulator_config_reg.pwm_rate;
      end
    end
  end

  // Next value of serial port format
  always_comb begin
    serial_port_format_next = serial_port_format_reg;
    if (reg_wr && sap_sel) begin
      serial_port_format_next = sap_wr;
      if (sap_wr.rate == `APC_RATE_RSVD) begin
        serial_port_format_next.rate = serial_port_format_reg.rate;
      end
      if (sap_wr.fmt == `APC_FMT_RSVD) begin
        serial_port_format_next.fmt = serial_port_format_reg.fmt;
      end
    end
  end

  // Modulator config storage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      modulator_config_reg <= apc_modcfg_t'(`APC_MODCFG_RST);
    end else begin
      modulator_config_reg <= modulator_config_next;
    end
  end

  // Serial port format storage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_port_format_reg <= apc_sapcfg_t'(`APC_SAPFMT_RST);
    end else begin
      serial_port_format_reg <= serial_port_format_next;
    end
  end

  // Read data, unmapped reads return zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (mod_sel) begin
        reg_rdata <= modulator_config_reg;
      end else if (sap_sel) begin
        reg_rdata <= serial_port_format_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Field decoder
  apc_decode u_decode (
    .mod_cfg(modulator_config_reg),
    .sap_cfg(serial_port_format_reg),
    .dec(dec)
  );

  // Registered settings to the datapath
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_out <= '0;
      serial_audio_port_fmt <= `APC_FMT_I2S;
    end else begin
      cfg_out <= dec;
      serial_audio_port_fmt <= serial_port_format_reg.fmt;
    end
  end

endmodule : apc_audio_port_pwm_config
`default_nettype wire

// [apc_checker_assertions.sv]
// Checker of register port and decoded settings
`timescale 1ns/100ps
`default_nettype none
module apc_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Decoded outputs
  input wire apc_pkg::apc_decoded_t cfg_out,
  input wire logic [2:0] serial_audio_port_fmt
);
  import apc_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Write strobes per register
  wire logic mw = reg_wr && reg_addr == 8'h02;
  wire logic sw = reg_wr && reg_addr == 8'h03;
  // Rate code 110 gives 44x
  AST_PWM: assert property (mw && reg_wdata[6:4] == 3'h6 |=> ##1 cfg_out.pwm_mult == 6'h2c)
    else $error("pwm multiple wrong");
  // Oversample bit to ratio
  AST_OSR: assert property (mw |=> ##1 cfg_out.osr == ($past(reg_wdata[2], 2) ? 8'h80 : 8'h40))
    else $error("oversample ratio wrong");
  // Phase code 01 gives 30 degrees
  AST_PHASE: assert property (mw && reg_wdata[1:0] == 2'h1 |=> ##1 cfg_out.phase_deg == 6'h1e)
    else $error("phase offset wrong");
  // Rate code 10 gives 96 kHz
  AST_FS: assert property (sw && reg_wdata[7:6] == 2'h2 |=> ##1 cfg_out.fs_khz_x10 == 10'h3c0)
    else $error("sample rate wrong");
  // Slot of channel one from half and swap
  AST_MAP: assert property (sw |=> ##1 cfg_out.slot_map[0] == {$past(reg_wdata[5], 2), $past(reg_wdata[3], 2), 1'b0})
    else $error("slot map wrong");
  // Legal format code taken
  AST_FMT: assert property (sw && reg_wdata[2:0] != 3'h7 |=> ##1 serial_audio_port_fmt == $past(reg_wdata[2:0], 2))
    else $error("format not taken");
  // Reserved format code ignored
  AST_RSVD: assert property (sw && reg_wdata[2:0] == 3'h7 |=> ##1 $stable(serial_audio_port_fmt))
    else $error("reserved format taken");
  // Read data holds between reads
  AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : apc_checker
bind apc_audio_port_pwm_config apc_checker u_apc_checker (.clock(clock), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cfg_out(cfg_out), .serial_audio_port_fmt(serial_audio_port_fmt));
`default_nettype wire

// [apc_host_model.sv]
// Host model issuing register writes and reads
`timescale 1ns/100ps
`default_nettype none
module apc_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle bus at start
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One strobe cycle, then released lines inverted
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : acc
endmodule : apc_host_model
`default_nettype wire

// [apc_audio_port_pwm_config_tb.sv]
// Testbench of the PWM and serial port configuration block
`timescale 1ns/100ps
`default_nettype none
module apc_audio_port_pwm_config_tb;
  import apc_pkg::*;
  logic clock, nrst, reg_wr, reg_rd, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, m, s, d;
  logic [2:0] serial_audio_port_fmt;
  apc_decoded_t cfg_out;
  logic [7:0] exp_q[$];
  int num_errors, samples_checked, cycles, seed;
  apc_host_model u_apc_host_model (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  apc_audio_port_pwm_config u_apc_audio_port_pwm_config (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_out(cfg_out), .serial_audio_port_fmt(serial_audio_port_fmt));
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task check(input string n, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask : check
  // Switching multiple per rate code
  function automatic logic [9:0] exp_mult(input logic [2:0] c);
    case (c)
      3'h0: return 10'h008;
      3'h1: return 10'h00a;
      3'h5: return 10'h026;
      3'h6: return 10'h02c;
      default: return 10'h030;
    endcase
  endfunction : exp_mult
  // Framing and right-justified width per format code
  function automatic logic [9:0] exp_frame(input logic [2:0] f);
    case (f)
      3'h0: return {3'h0, APC_FRAME_RJ, 5'h18};
      3'h1: return {3'h0, APC_FRAME_RJ, 5'h14};
      3'h2: return {3'h0, APC_FRAME_RJ, 5'h12};
      3'h3: return {3'h0, APC_FRAME_RJ, 5'h10};
      3'h5: return {3'h0, APC_FRAME_LJ, 5'h00};
      3'h6: return {3'h0, APC_FRAME_DSP, 5'h00};
      default: return {3'h0, APC_FRAME_I2S, 5'h00};
    endcase
  endfunction : exp_frame
  task conclude;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_apc_host_model.acc(1'b0, a, 8'h00);
  endtask : rd
  // Defaults after a reset release
  task reset_test;
    rd(8'h02, 8'h62);
    rd(8'h03, 8'h04);
    rd(8'h05, 8'h00);
    check("pwm0", {4'h0, cfg_out.pwm_mult}, 10'h02c);
    check("phase0", {4'h0, cfg_out.phase_deg}, 10'h02d);
    check("osr0", {2'h0, cfg_out.osr}, 10'h040);
    check("fmt0", {7'h00, serial_audio_port_fmt}, 10'h004);
    $display("reset test done");
  endtask : reset_test
  // Compare each read result with the oldest note
  always @(posedge clock) rd_d <= reg_rd;
  always @(negedge clock) begin
    if (rd_d === 1'b1) check("rdata", {2'h0, reg_rdata}, {2'h0, exp_q.pop_front()});
  end
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    seed = 79;
    nrst = 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    m = 8'h62;
    s = 8'h04;
    reset_test();
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[6:4] = i[2:0];
      m = {d[7], (d[6:4] > 3'h1 && d[6:4] < 3'h5) ? m[6:4] : d[6:4], d[3:0]};
      u_apc_host_model.acc(1'b1, 8'h02, d);
      d = 8'($random(seed));
      d[2:0] = i[2:0];
      d[7:6] = i[1:0];
      s = {(d[7:6] == 2'h3) ? s[7:6] : d[7:6], d[5:3], (d[2:0] == 3'h7) ? s[2:0] : d[2:0]};
      u_apc_host_model.acc(1'b1, 8'h03, d);
      rd(8'h02, m);
      rd(8'h03, s);
      check("osr", {2'h0, cfg_out.osr}, m[2] ? 10'h080 : 10'h040);
      check("fs", cfg_out.fs_khz_x10, s[7] ? 10'h3c0 : s[6] ? 10'h1e0 : 10'h1b9);
      check("map", {7'h00, cfg_out.slot_map[0]}, {7'h00, s[5], s[3], 1'b0});
      check("bits", {3'h0, cfg_out.slot_wide, cfg_out.slot_bits}, s[4] ? 10'h010 : 10'h060);
      check("fmt", {7'h00, serial_audio_port_fmt}, {7'h00, s[2:0]});
      check("pwm", {4'h0, cfg_out.pwm_mult}, exp_mult(m[6:4]));
      check("unsup", {9'h000, cfg_out.pwm_unsupported}, {9'h000, m[6:4] == 3'h7 && s[7:6] != 2'h0});
      check("phase", {4'h0, cfg_out.phase_deg}, m[1] ? (m[0] ? 10'h03c : 10'h02d) : (m[0] ? 10'h01e : 10'h000));
      check("frame", {3'h0, cfg_out.frame, cfg_out.rj_bits}, exp_frame(s[2:0]));
      check("map13", {4'h0, cfg_out.slot_map[3], cfg_out.slot_map[1]}, {4'h0, s[5], ~s[3], 1'b1, s[5], s[3], 1'b1});
    end
    $display("field test done");
    // Reset again in mid-run, defaults must return
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    reset_test();
    conclude();
  end
endmodule : apc_audio_port_pwm_config_tb
`default_nettype wire
